// File: logic/dmbs_bank_select.sv
// Overview of operation
// R1: two bank address bits select exactly one of four banks.
// R2: eight low address outputs go in common to every chip.
// R3: address bits eleven and ten stay unused in four-bank arrays.
// R4: per-bank row strobes captured at controller row strobe fall, stable all cycle.
// R5: bank strobe stays low with row strobe, cleared at once when it ends.
// R6: read, write or transfer cycles activate only the addressed bank.
// R7: refresh cycles activate all four bank strobes together.
// R8: column strobe low before row fall means refresh, else normal cycle.
// R9: each bank strobe reaches all sixteen chips of its bank.
// R10: all memory interface logic runs on the single system clock.
// R11: serial port and shifter data strobes are system-clock synchronous.
// R12: sync, blank and fifo reads follow the asynchronous video clock.
// R13: one write enable per plane, each fanned to sixteen chips.
// R14: transfer gate buffered to all chips, raw copy kept for local logic.
// R15: each bank is 64K by 16 per plane, four planes of four banks.
// R16: four display planes of 2048 by 2048 pixels each.
// R17: bank bits map in binary order onto banks zero to three.
// R18: bank address held in two flops loaded by the transfer pulse.
// R19: bank flop sets only when addressed or refresh, else stays idle.
`timescale 1ns/1ps
`default_nettype none

`include "dmbs_defs.svh"

module dmbs_bank_select #(
    parameter int unsigned NUM_BANKS = `DMBS_NUM_BANKS,
    parameter int unsigned NUM_PLANES = `DMBS_NUM_PLANES,
    parameter int unsigned CHIPS_PER_BANK_PLANE = `DMBS_CHIPS_PER_BANK_PLANE,
    parameter int unsigned CHIPS_PER_PLANE = `DMBS_CHIPS_PER_PLANE,
    parameter int unsigned PLANE_PIXELS = `DMBS_PLANE_PIXELS,
    parameter int unsigned BANK_WORDS = `DMBS_BANK_WORDS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [`DMBS_ADDR_W-1:0] ctl_addr,
    input wire logic ctl_ras_n,
    input wire logic ctl_cas_n,
    input wire logic [`DMBS_NUM_PLANES-1:0] ctl_we_n,
    input wire logic transfer_gate_n,
    input wire logic serial_port_strobe,
    input wire logic shifter_data_strobe,
    input wire logic video_clock,
    input wire logic ctl_hsync,
    input wire logic ctl_vsync,
    input wire logic ctl_blank,
    output logic [`DMBS_ROW_ADDR_W-1:0] mem_addr,
    output logic [`DMBS_NUM_BANKS-1:0] bank_row_strobe_n,
    output logic [`DMBS_NUM_CHIPS-1:0] chip_row_strobe_n,
    output logic [`DMBS_NUM_PLANES-1:0] plane_we_n,
    output logic [`DMBS_NUM_CHIPS-1:0] chip_we_n,
    output logic transfer_gate_buf_n,
    output logic transfer_gate_local_n,
    output logic transfer_pulse,
    output dmbs_pkg::dmbs_bank_t transfer_pulse_bank,
    output dmbs_pkg::dmbs_bank_mask_t transfer_pulse_bank_sel,
    output logic refresh_cycle,
    output logic serial_port_strobe_out,
    output logic shifter_data_strobe_out,
    output logic hsync,
    output logic vsync,
    output logic blank,
    output logic fifo_read
);
    import dmbs_pkg::*;

    // one-hot bank choice from the two bank bits, binary order
    function automatic dmbs_bank_mask_t dmbs_bank_decode(input dmbs_bank_t sel);
        dmbs_bank_mask_t mask;
        mask = '0;
        mask[sel] = 1'b1; // 00 -> bank 0 ... 11 -> bank 3 [R17]
        return mask;
    endfunction : dmbs_bank_decode

    // geometry: four planes of four 64K by 16 banks cover 2048 by 2048 pixels
    localparam int unsigned PLANE_WORDS = NUM_BANKS * BANK_WORDS; // [R15]
    localparam int unsigned PLANE_BITS = PLANE_WORDS * `DMBS_WORD_W; // [R16]
    localparam int unsigned PIXELS_PER_PLANE = PLANE_PIXELS * PLANE_PIXELS;

    // memory cycle tracking, all on the system clock [R10]
    dmbs_cyc_t cyc_q;
    dmbs_cyc_t cyc_d;
    logic ras_n_q;
    logic ras_fall;
    logic ras_rise;
    logic refresh_now;
    dmbs_bank_t bank_bits;
    dmbs_bank_mask_t bank_set;
    dmbs_bank_mask_t bank_act_q;
    dmbs_bank_mask_t bank_act;
    logic transfer_pulse_q;
    logic transfer_pulse_set;
    dmbs_bank_t transfer_pulse_bank_q;
    logic [`DMBS_ROW_ADDR_W-1:0] mem_addr_q;
    logic [`DMBS_NUM_PLANES-1:0] plane_we_n_q;
    logic tg_n_q;
    logic sps_q;
    logic sds_q;

    // bank bits sit just above the row/column address
    assign bank_bits = ctl_addr[`DMBS_BANK_MSB:`DMBS_BANK_LSB]; // [R1]

    // edges of the controller row strobe; it comes from the same clock
    // domain, so no synchroniser is needed and no cycle of latency is lost
    assign ras_fall = ras_n_q && !ctl_ras_n;
    assign ras_rise = !ras_n_q && ctl_ras_n;

    // column strobe already low at the row fall marks a refresh [R8]
    assign refresh_now = !ctl_cas_n;

    // j/k inputs: addressed bank only, or every bank during refresh [R19]
    assign bank_set = refresh_now ? {`DMBS_NUM_BANKS{1'b1}} // [R7]
                                  : dmbs_bank_decode(bank_bits); // [R1] [R6]

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ras_n_q <= 1'b1;
        else if (ce)
            ras_n_q <= ctl_ras_n;
    end

    // cycle kind
    always_comb
    begin
        cyc_d = cyc_q;
        unique case (cyc_q)
            DMBS_CYC_IDLE:
            begin
                if (ras_fall)
                    cyc_d = refresh_now ? DMBS_CYC_REFRESH : DMBS_CYC_NORMAL; // [R8]
            end
            DMBS_CYC_NORMAL,
            DMBS_CYC_REFRESH:
            begin
                if (ras_rise)
                    cyc_d = DMBS_CYC_IDLE;
            end
            default:
                cyc_d = DMBS_CYC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cyc_q <= DMBS_CYC_IDLE;
        else if (ce)
            cyc_q <= cyc_d;
    end

    assign refresh_cycle = (cyc_q == DMBS_CYC_REFRESH);

    // bank flops: loaded only at the row fall, so a change of the bank bits
    // mid-cycle can not move the strobe to another bank [R4]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            bank_act_q <= '0;
        else if (ce)
        begin
            if (ras_fall)
                bank_act_q <= bank_set; // [R19]
            else if (ctl_ras_n)
                bank_act_q <= '0; // [R5]
        end
    end

    // the set acts in the fall cycle itself; the clear is combinational from
    // the row strobe, the synchronous stand-in for the flop's async clear
    assign bank_act = ras_fall ? bank_set : bank_act_q;

    always_comb
    begin
        for (int b = 0; b < `DMBS_NUM_BANKS; b++)
            bank_row_strobe_n[b] = !(bank_act[b] && !ctl_ras_n); // [R4] [R5]
    end

    // each bank strobe fans to four chips in each of the four planes [R9]
    genvar gp;
    genvar gb;
    genvar gc;
    generate
        for (gp = 0; gp < NUM_PLANES; gp++)
        begin : g_plane
            for (gb = 0; gb < NUM_BANKS; gb++)
            begin : g_bank
                for (gc = 0; gc < CHIPS_PER_BANK_PLANE; gc++)
                begin : g_chip
                    assign chip_row_strobe_n[gp*CHIPS_PER_PLANE
                        + gb*CHIPS_PER_BANK_PLANE + gc] = bank_row_strobe_n[gb]; // [R9]
                end
            end
        end
    endgenerate

    // low eight address bits, registered, common to all chips [R2]
    // bits eleven and ten are not looked at here at all [R3]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mem_addr_q <= `DMBS_RST_ADDR;
        else if (ce)
            mem_addr_q <= ctl_addr[`DMBS_ROW_ADDR_W-1:0]; // [R2]
    end

    assign mem_addr = mem_addr_q;

    // per-plane write enables, registered [R13]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            plane_we_n_q <= `DMBS_RST_STROBES_N;
        else if (ce)
            plane_we_n_q <= ctl_we_n; // [R13]
    end

    assign plane_we_n = plane_we_n_q;

    // each plane enable drives all sixteen chips of its plane [R13]
    genvar gw;
    generate
        for (gw = 0; gw < `DMBS_NUM_CHIPS; gw++)
        begin : g_we
            assign chip_we_n[gw] = plane_we_n_q[gw / CHIPS_PER_PLANE];
        end
    endgenerate

    // buffered gate to the array; the raw pin stays for local logic [R14]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            tg_n_q <= 1'b1;
        else if (ce)
            tg_n_q <= transfer_gate_n; // [R14]
    end

    assign transfer_gate_buf_n = tg_n_q;
    assign transfer_gate_local_n = transfer_gate_n; // [R14]

    // transfer pulse: set at a row fall with the gate already low,
    // cleared as soon as the gate goes high again
    assign transfer_pulse_set = ras_fall && !transfer_gate_n;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            transfer_pulse_q <= 1'b0;
        else if (ce)
        begin
            if (transfer_pulse_set)
                transfer_pulse_q <= 1'b1;
            else if (transfer_gate_n)
                transfer_pulse_q <= 1'b0;
        end
    end

    assign transfer_pulse = (transfer_pulse_q || transfer_pulse_set) && !transfer_gate_n;

    // bank latch for the serial side, held between transfers [R18]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            transfer_pulse_bank_q <= `DMBS_RST_BANK;
        else if (ce && transfer_pulse_set)
            transfer_pulse_bank_q <= bank_bits; // [R18]
    end

    assign transfer_pulse_bank = transfer_pulse_bank_q;
    assign transfer_pulse_bank_sel = dmbs_bank_decode(transfer_pulse_bank_q); // [R17]

    // serial strobes retimed on the system clock toward the shifter [R11]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sps_q <= 1'b0;
            sds_q <= 1'b0;
        end
        else if (ce)
        begin
            sps_q <= serial_port_strobe; // [R11]
            sds_q <= shifter_data_strobe; // [R11]
        end
    end

    assign serial_port_strobe_out = sps_q;
    assign shifter_data_strobe_out = sds_q;

    // video timing stage on the system clock, stepped by the foreign video clock [R12]
    dmbs_video_if vif ();

    assign vif.hsync_src = ctl_hsync;
    assign vif.vsync_src = ctl_vsync;
    assign vif.blank_src = ctl_blank;

    dmbs_video_stage u_video (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .video_clock(video_clock),
        .vif(vif.video)
    );

    assign hsync = vif.hsync;
    assign vsync = vif.vsync;
    assign blank = vif.blank;
    assign fifo_read = vif.fifo_read;

    // checks
    default clocking dmbs_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_refresh_all_banks: assert property ( // [R7]
        ras_fall && !ctl_cas_n |-> bank_row_strobe_n == 4'h0)
    else $error("refresh did not open all banks");

    chk_normal_single_bank: assert property ( // [R6]
        ras_fall && ctl_cas_n |-> $onehot(~bank_row_strobe_n))
    else $error("normal cycle opened other than one bank");

    chk_bank_binary_map: assert property ( // [R17]
        ras_fall && ctl_cas_n |-> ~bank_row_strobe_n == dmbs_bank_decode(bank_bits))
    else $error("bank strobe does not match bank bits");

    chk_strobe_release: assert property ( // [R5]
        ctl_ras_n |-> bank_row_strobe_n == 4'hF)
    else $error("bank strobe active with row strobe high");

    chk_strobe_stable: assert property ( // [R4]
        ce && !ctl_ras_n ##1 !ctl_ras_n |-> $stable(bank_row_strobe_n))
    else $error("bank strobe moved inside a cycle");

    chk_addr_follow: assert property ( // [R2]
        ce |=> mem_addr == $past(ctl_addr[7:0]))
    else $error("row address output did not follow");

    chk_plane_we: assert property ( // [R13]
        ce |=> plane_we_n == $past(ctl_we_n) && chip_we_n[16] == plane_we_n[1])
    else $error("plane write enable wrong");

    chk_transfer_pulse_bank_load: assert property ( // [R18]
        ce && transfer_pulse_set |=> transfer_pulse_bank == $past(bank_bits) && transfer_pulse_bank_sel == 4'h1 << $past(bank_bits))
    else $error("transfer bank not latched");

    chk_transfer_pulse_gate_clear: assert property ( // [R18]
        transfer_gate_n |-> !transfer_pulse)
    else $error("transfer pulse with gate high");

    chk_refresh_flag: assert property ( // [R8]
        ce && ras_fall && !ctl_cas_n |=> refresh_cycle)
    else $error("refresh not recognised");

endmodule : dmbs_bank_select

`default_nettype wire

// File: logic/dmbs_defs.svh
`ifndef DMBS_DEFS_SVH
`define DMBS_DEFS_SVH

// array geometry
`define DMBS_NUM_BANKS 4
`define DMBS_NUM_PLANES 4
`define DMBS_CHIPS_PER_BANK_PLANE 4
`define DMBS_CHIPS_PER_PLANE 16
`define DMBS_NUM_CHIPS 64
`define DMBS_BANK_WORDS 65536
`define DMBS_WORD_W 16
`define DMBS_PLANE_PIXELS 2048

// controller address layout
`define DMBS_ADDR_W 12
`define DMBS_ROW_ADDR_W 8
`define DMBS_BANK_LSB 8
`define DMBS_BANK_MSB 9
`define DMBS_SPARE_LSB 10
`define DMBS_SPARE_MSB 11

// reset values
`define DMBS_RST_STROBES_N 4'hF
`define DMBS_RST_ADDR 8'h00
`define DMBS_RST_BANK 2'h0

// timing
`define DMBS_CLK_PERIOD_NS 5
`define DMBS_SYNC_STAGES 3

`endif

// File: logic/dmbs_pkg.sv
`default_nettype none

package dmbs_pkg;

    // memory cycle kind, one-hot
    typedef enum logic [2:0] {
        DMBS_CYC_IDLE    = 3'h1,
        DMBS_CYC_NORMAL  = 3'h2,
        DMBS_CYC_REFRESH = 3'h4
    } dmbs_cyc_t;

    typedef logic [1:0] dmbs_bank_t;
    typedef logic [3:0] dmbs_bank_mask_t;

endpackage : dmbs_pkg

`default_nettype wire

// File: logic/dmbs_video_if.sv
`timescale 1ns/1ps
`default_nettype none

// video-side signals between the core and the video timing stage
interface dmbs_video_if;
    logic hsync_src;
    logic vsync_src;
    logic blank_src;
    logic hsync;
    logic vsync;
    logic blank;
    logic fifo_read;

    modport core (output hsync_src, output vsync_src, output blank_src,
                  input hsync, input vsync, input blank, input fifo_read);
    modport video (input hsync_src, input vsync_src, input blank_src,
                   output hsync, output vsync, output blank, output fifo_read);
endinterface : dmbs_video_if

`default_nettype wire

// File: logic/dmbs_video_stage.sv
`timescale 1ns/1ps
`default_nettype none

`include "dmbs_defs.svh"

module dmbs_video_stage (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic video_clock,
    dmbs_video_if.video vif
);
    import dmbs_pkg::*;

    logic [`DMBS_SYNC_STAGES-1:0] vclk_sync_q;
    logic vclk_level_q;
    logic vclk_rise;

    // three-stage catch of the foreign video clock
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            vclk_sync_q <= '0;
        else if (ce)
            vclk_sync_q <= {vclk_sync_q[`DMBS_SYNC_STAGES-2:0], video_clock};
    end

    // a change only counts once stages two and three agree
    assign vclk_rise = (vclk_sync_q[1] == vclk_sync_q[2]) && vclk_sync_q[2] && !vclk_level_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            vclk_level_q <= 1'b0;
        else if (ce && (vclk_sync_q[1] == vclk_sync_q[2]))
            vclk_level_q <= vclk_sync_q[2];
    end

    // sync outputs and fifo reads step on rising video clock edges only [R12]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            vif.hsync <= 1'b0;
            vif.vsync <= 1'b0;
            vif.blank <= 1'b1;
            vif.fifo_read <= 1'b0;
        end
        else if (ce)
        begin
            vif.fifo_read <= vclk_rise; // one-cycle pulse per video clock [R12]
            if (vclk_rise)
            begin
                vif.hsync <= vif.hsync_src;
                vif.vsync <= vif.vsync_src;
                vif.blank <= vif.blank_src;
            end
        end
    end

endmodule : dmbs_video_stage

`default_nettype wire

// File: testbench/dmbs_vram_model.sv
`timescale 1ns/1ps
`default_nettype none

// passive view of the video memory array across four planes and four banks
module dmbs_vram_model (
    input wire logic [63:0] chip_row_strobe_n,
    input wire logic [63:0] chip_we_n,
    output logic [3:0] bank_active,
    output logic fanout_ok
);
    // a bank counts as active only if every chip of it, in every plane, is strobed
    always_comb
    begin
        fanout_ok = 1'b1;
        for (int b = 0; b < 4; b++)
        begin
            bank_active[b] = 1'b1;
            for (int p = 0; p < 4; p++)
                for (int c = 0; c < 4; c++)
                begin
                    bank_active[b] &= ~chip_row_strobe_n[p*16+b*4+c];
                    if (chip_row_strobe_n[p*16+b*4+c] !== chip_row_strobe_n[b*4])
                        fanout_ok = 1'b0;
                end
        end
        // a plane's write enable must reach its sixteen chips alike
        for (int i = 0; i < 64; i++)
            if (chip_we_n[i] !== chip_we_n[(i/16)*16])
                fanout_ok = 1'b0;
    end
endmodule : dmbs_vram_model

`default_nettype wire

// File: testbench/tb_display_memory_bank_select.sv
`timescale 1ns/1ps
`default_nettype none

module tb_display_memory_bank_select;
    import dmbs_pkg::*;

    logic clk, rstn, ce, ctl_ras_n, ctl_cas_n, transfer_gate_n;
    logic serial_port_strobe, shifter_data_strobe, video_clock;
    logic ctl_hsync, ctl_vsync, ctl_blank;
    logic [11:0] ctl_addr;
    logic [3:0] ctl_we_n, bank_row_strobe_n, plane_we_n, model_active;
    logic [7:0] mem_addr;
    logic [63:0] chip_row_strobe_n, chip_we_n;
    logic transfer_gate_buf_n, transfer_gate_local_n, transfer_pulse, refresh_cycle;
    logic serial_port_strobe_out, shifter_data_strobe_out, hsync, vsync, blank, fifo_read;
    logic model_fanout_ok;
    dmbs_bank_t transfer_pulse_bank;
    dmbs_bank_mask_t transfer_pulse_bank_sel;
    logic [1:0] xb_exp;
    int miscompares, tests_run;

    dmbs_bank_select dut (
        .clk(clk), .rstn(rstn), .ce(ce), .ctl_addr(ctl_addr), .ctl_ras_n(ctl_ras_n),
        .ctl_cas_n(ctl_cas_n), .ctl_we_n(ctl_we_n), .transfer_gate_n(transfer_gate_n),
        .serial_port_strobe(serial_port_strobe), .shifter_data_strobe(shifter_data_strobe),
        .video_clock(video_clock), .ctl_hsync(ctl_hsync), .ctl_vsync(ctl_vsync),
        .ctl_blank(ctl_blank), .mem_addr(mem_addr), .bank_row_strobe_n(bank_row_strobe_n),
        .chip_row_strobe_n(chip_row_strobe_n), .plane_we_n(plane_we_n), .chip_we_n(chip_we_n),
        .transfer_gate_buf_n(transfer_gate_buf_n), .transfer_gate_local_n(transfer_gate_local_n),
        .transfer_pulse(transfer_pulse), .transfer_pulse_bank(transfer_pulse_bank), .transfer_pulse_bank_sel(transfer_pulse_bank_sel),
        .refresh_cycle(refresh_cycle), .serial_port_strobe_out(serial_port_strobe_out),
        .shifter_data_strobe_out(shifter_data_strobe_out), .hsync(hsync), .vsync(vsync),
        .blank(blank), .fifo_read(fifo_read)
    );

    dmbs_vram_model model (
        .chip_row_strobe_n(chip_row_strobe_n), .chip_we_n(chip_we_n),
        .bank_active(model_active), .fanout_ok(model_fanout_ok)
    );

    // 200 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // values seen while reset is still held
    task automatic reset_values();
        chk(bank_row_strobe_n, 4'hF);
        chk(mem_addr, 8'h00);
        chk(plane_we_n, 4'hF);
        chk({transfer_gate_buf_n, transfer_gate_local_n}, 2'h3);
        chk(transfer_pulse_bank_sel, 4'h1);
        chk(refresh_cycle, 1'h0);
        chk({serial_port_strobe_out, shifter_data_strobe_out}, 2'h0);
        chk({hsync, vsync, blank, fifo_read}, 4'h2);
    endtask : reset_values

    // reset in mid-run must clear every latch at once; one plain cycle after it
    task automatic mid_reset();
        @(negedge clk);
        rstn = 1'b0;
        xb_exp = 2'h0;
        #1;
        reset_values();
        @(negedge clk);
        rstn = 1'b1;
        mem_cycle(2'h1, 1'b0, 1'b1);
    endtask : mid_reset

    // one memory cycle; bank bits move after the fall to prove the latch holds
    task automatic mem_cycle(input logic [1:0] bank, input logic refresh, input logic gate_n);
        logic [3:0] exp;
        logic [3:0] act;
        exp = refresh ? 4'h0 : ~(4'h1 << bank);
        act = ~exp;
        if (!gate_n)
            xb_exp = bank;
        @(negedge clk);
        ctl_cas_n = !refresh;
        transfer_gate_n = gate_n;
        ctl_addr = {2'h3, bank, 8'h5A};
        @(negedge clk);
        ctl_ras_n = 1'b0;
        #1;
        chk(bank_row_strobe_n, exp);
        chk(transfer_pulse, !gate_n);
        @(negedge clk);
        ctl_addr[9:8] = ~bank;
        ctl_cas_n = 1'b0;
        #1;
        chk(bank_row_strobe_n, exp);
        chk(model_active, act);
        chk(refresh_cycle, refresh);
        chk(transfer_pulse_bank, xb_exp);
        chk(transfer_pulse_bank_sel, 4'h1 << xb_exp);
        @(negedge clk);
        ctl_ras_n = 1'b1;
        #1;
        chk(bank_row_strobe_n, 4'hF);
        chk(transfer_pulse, !gate_n);
        @(negedge clk);
        ctl_cas_n = 1'b1;
        transfer_gate_n = 1'b1;
        #1;
        chk(transfer_pulse, 1'h0);
    endtask : mem_cycle

    // buffered address, enables and strobes, then a frozen cycle with ce low
    task automatic pass_through();
        @(negedge clk);
        ctl_addr = 12'hFA5;
        ctl_we_n = 4'hA;
        transfer_gate_n = 1'b0;
        serial_port_strobe = 1'b1;
        shifter_data_strobe = 1'b1;
        #1;
        chk(transfer_gate_local_n, 1'h0);
        @(negedge clk);
        chk(mem_addr, 8'hA5);
        chk(plane_we_n, 4'hA);
        chk(chip_we_n, 64'hFFFF0000FFFF0000);
        chk(model_fanout_ok, 1'h1);
        chk(transfer_gate_buf_n, 1'h0);
        chk({serial_port_strobe_out, shifter_data_strobe_out}, 2'h3);
        ce = 1'b0;
        ctl_addr = 12'h0C3;
        transfer_gate_n = 1'b1;
        @(negedge clk);
        chk(mem_addr, 8'hA5);
        ce = 1'b1;
        ctl_we_n = 4'hF;
        serial_port_strobe = 1'b0;
        shifter_data_strobe = 1'b0;
        @(negedge clk);
        chk(mem_addr, 8'hC3);
        chk({serial_port_strobe_out, shifter_data_strobe_out}, 2'h0);
    endtask : pass_through

    // three slow video clock rises, each must give one fifo read
    task automatic video();
        int seen;
        seen = 0;
        ctl_hsync = 1'b1;
        ctl_vsync = 1'b1;
        ctl_blank = 1'b0;
        repeat (3)
        begin
            @(negedge clk);
            video_clock = 1'b1;
            repeat (8)
            begin
                @(negedge clk);
                seen += fifo_read;
            end
            video_clock = 1'b0;
            repeat (8)
            begin
                @(negedge clk);
                seen += fifo_read;
            end
        end
        chk(seen, 3);
        chk({hsync, vsync, blank}, 3'h6);
    endtask : video

    // hang guard, far beyond the hundred or so cycles the run needs
    initial
    begin
        #20000;
        miscompares++;
        conclude();
    end

    initial
    begin
        miscompares = 0;
        tests_run = 0;
        xb_exp = 2'h0;
        rstn = 1'b0;
        ce = 1'b1;
        ctl_addr = 12'h000;
        ctl_ras_n = 1'b1;
        ctl_cas_n = 1'b1;
        ctl_we_n = 4'hF;
        transfer_gate_n = 1'b1;
        serial_port_strobe = 1'b0;
        shifter_data_strobe = 1'b0;
        video_clock = 1'b0;
        ctl_hsync = 1'b0;
        ctl_vsync = 1'b0;
        ctl_blank = 1'b1;
        repeat (3) @(negedge clk);
        reset_values();
        rstn = 1'b1;
        for (int b = 0; b < 4; b++)
            mem_cycle(b[1:0], 1'b0, 1'b1);
        mem_cycle(2'h1, 1'b1, 1'b1);
        mem_cycle(2'h3, 1'b0, 1'b0);
        mem_cycle(2'h2, 1'b0, 1'b0);
        mem_cycle(2'h0, 1'b0, 1'b1);
        pass_through();
        video();
        mid_reset();
        conclude();
    end
endmodule : tb_display_memory_bank_select

`default_nettype wire
